/* entry_check_defs.svh */
`ifndef ENTRY_CHECK_DEFS_SVH
`define ENTRY_CHECK_DEFS_SVH

// Register byte offsets
`define OFF_CTRL 7'h00
`define OFF_STATUS 7'h04
`define OFF_FAIL 7'h08
`define OFF_ACTIVITY 7'h0C
`define OFF_INTERRUPTIBILITY 7'h10
`define OFF_PDBG_LO 7'h14
`define OFF_PDBG_HI 7'h18
`define OFF_LINK_LO 7'h1C
`define OFF_LINK_HI 7'h20
`define OFF_INJECTION 7'h24
`define OFF_FLAGS 7'h28
`define OFF_DEBUG_CTL 7'h2C
`define OFF_SS_ACCESS 7'h30
`define OFF_FEATURE 7'h34
`define OFF_PTB_LO 7'h38
`define OFF_PTB_HI 7'h3C
`define OFF_CUR_LO 7'h40
`define OFF_CUR_HI 7'h44
`define OFF_ROOT_LO 7'h48
`define OFF_ROOT_HI 7'h4C
`define REG_COUNT 20

// Register indices
`define IDX_CTRL 5'd0
`define IDX_STATUS 5'd1
`define IDX_FAIL 5'd2
`define IDX_ACTIVITY 5'd3
`define IDX_INTR 5'd4
`define IDX_PDBG_LO 5'd5
`define IDX_PDBG_HI 5'd6
`define IDX_LINK_LO 5'd7
`define IDX_LINK_HI 5'd8
`define IDX_INJ 5'd9
`define IDX_FLAGS 5'd10
`define IDX_DBGCTL 5'd11
`define IDX_SS_AR 5'd12
`define IDX_FEATURE 5'd13
`define IDX_PTB_LO 5'd14
`define IDX_PTB_HI 5'd15
`define IDX_CUR_LO 5'd16
`define IDX_CUR_HI 5'd17
`define IDX_ROOT_LO 5'd18
`define IDX_ROOT_HI 5'd19

// Control bits
`define CTRL_START 0
`define CTRL_IN_MGMT 1
`define CTRL_ENTRY_MGMT 2
`define CTRL_VIRT_NMI 3
`define CTRL_GUEST64 4
`define CTRL_PREV_PAGING 5
`define CTRL_STRICT_SHADOW 6

// Field positions
`define ACT_MAX 32'h0000_0003
`define SS_PRIV_HI 6
`define SS_PRIV_LO 5
`define INTR_IE_SHADOW 0
`define INTR_MOVSS 1
`define INTR_MGMT_BLOCK 2
`define INTR_NMI 3
`define INJ_VALID 31
`define INJ_TYPE_HI 10
`define INJ_TYPE_LO 8
`define FLAGS_TRAP 8
`define FLAGS_IF 9
`define DBGCTL_BRANCH_TRAP 1
`define PDBG_STEP 14
`define FEATURE_EXT_PAGING 5
`define INJ_EXT 3'h0
`define INJ_NMI 3'h2
`define INJ_HWEXC 3'h3
`define VEC_DEBUG 8'h01
`define VEC_MCHK 8'h12
`define PDBG_RSVD 64'hFFFF_FFFF_FFFF_AFF0
`define PDPTE_RSVD 64'h0000_0000_0000_01E6

// Failure vector positions
`define FAIL_BITS 19
`define F_LINK_FMT 15
`define F_LINK_SAME 16
`define F_REVISION 17
`define F_PDPT 18

// Reset values
`define LINK_RESET 32'hFFFF_FFFF
`define REG_RESET 32'h0000_0000
`endif

/* entry_check_pkg.sv */
package entry_check_pkg;
    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_static = 3'b001,
        st_link = 3'b011,
        st_pdpt = 3'b010,
        st_finish = 3'b110
    } state_t;

    typedef enum logic [1:0] {
        act_active = 2'h0,
        act_halted = 2'h1,
        act_shutdown = 2'h2,
        act_await = 2'h3
    } activity_t;
endpackage : entry_check_pkg

/* guest_state_entry_checker.sv */
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "entry_check_defs.svh"
module guest_state_entry_checker #(
    parameter int PHYS_WIDTH = 36,
    parameter logic [31:0] REVISION_ID = 32'h0000_0001 // Arbitrary value
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [6:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Physical memory read port
    output logic mem_req,
    output logic [63:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [63:0] mem_rdata,
    // Entry sequencing
    output logic state_load_go,
    input wire logic load_done,
    output logic entry_pass,
    output logic entry_fail,
    output logic msr_load_start
);
    // ----------------------------------------
    // Register file
    // ----------------------------------------
    logic [31:0] regs [0:`REG_COUNT-1];
    entry_check_pkg::state_t state;
    logic [`FAIL_BITS-1:0] fail_vec;
    logic [`FAIL_BITS-1:0] static_fail;
    logic start_pulse;
    logic done_flag;
    logic [63:0] last_ptb;
    logic [1:0] pdpt_idx;
    logic pdpt_needed;

    wire logic [4:0] idx = paddr[6:2];
    wire logic mapped = (idx < 5'(`REG_COUNT));
    wire logic access = psel && penable && pready;
    wire logic wr_ok = access && pwrite && mapped;

    function automatic logic [63:0] pair(input logic [31:0] lo, input logic [31:0] hi);
        pair = {hi, lo};
    endfunction : pair

    // Bits above the physical-address width all clear
    function automatic logic fits_phys(input logic [63:0] a);
        fits_phys = ((a >> PHYS_WIDTH) == 64'h0);
    endfunction : fits_phys

    wire logic [63:0] link = pair(regs[`IDX_LINK_LO], regs[`IDX_LINK_HI]);
    wire logic [63:0] pdbg = pair(regs[`IDX_PDBG_LO], regs[`IDX_PDBG_HI]);
    wire logic [63:0] ptb = pair(regs[`IDX_PTB_LO], regs[`IDX_PTB_HI]);
    wire logic [63:0] cur_ptr = pair(regs[`IDX_CUR_LO], regs[`IDX_CUR_HI]);
    wire logic [63:0] root_ptr = pair(regs[`IDX_ROOT_LO], regs[`IDX_ROOT_HI]);
    wire logic [31:0] ctrl = regs[`IDX_CTRL];
    wire logic [31:0] intr = regs[`IDX_INTR];
    wire logic [31:0] inj = regs[`IDX_INJ];
    wire logic link_skip = (link == 64'hFFFF_FFFF_FFFF_FFFF);
    wire logic ext_paging = regs[`IDX_FEATURE][`FEATURE_EXT_PAGING] && !ctrl[`CTRL_GUEST64];
    wire logic busy = (state != entry_check_pkg::st_idle);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `REG_COUNT; i++) begin
                regs[i] <= `REG_RESET;
            end
            regs[`IDX_LINK_LO] <= `LINK_RESET;
            regs[`IDX_LINK_HI] <= `LINK_RESET;
        end else if (wr_ok && idx != `IDX_STATUS && idx != `IDX_FAIL) begin
            regs[idx] <= pwdata;
            if (idx == `IDX_CTRL) begin
                regs[idx][`CTRL_START] <= 1'b0;
            end
        end
    end

    // Start ignored while a check is running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_pulse <= 1'b0;
        end else begin
            start_pulse <= wr_ok && idx == `IDX_CTRL && pwdata[`CTRL_START] && !busy;
        end
    end

    // ----------------------------------------
    // APB answer
    // ----------------------------------------
    // One wait state keeps prdata registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= !mapped;
            if (!mapped || pwrite) begin
                prdata <= 32'h0000_0000;
            end else if (idx == `IDX_STATUS) begin
                prdata <= {29'h0, entry_pass_seen(fail_vec, done_flag), done_flag, busy};
            end else if (idx == `IDX_FAIL) begin
                prdata <= {13'h0, fail_vec};
            end else begin
                prdata <= regs[idx];
            end
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    function automatic logic entry_pass_seen(input logic [`FAIL_BITS-1:0] f, input logic d);
        entry_pass_seen = d && (f == '0);
    endfunction : entry_pass_seen

    // ----------------------------------------
    // Static checks
    // ----------------------------------------
    always_comb begin
        logic [31:0] act;
        logic ies;
        logic movss;
        logic v;
        logic [2:0] typ;
        logic [7:0] vec;
        logic inj_ok;
        logic bs_want;
        act = regs[`IDX_ACTIVITY];
        ies = intr[`INTR_IE_SHADOW];
        movss = intr[`INTR_MOVSS];
        v = inj[`INJ_VALID];
        typ = inj[`INJ_TYPE_HI:`INJ_TYPE_LO];
        vec = inj[7:0];
        inj_ok = 1'b1;
        static_fail = '0;
        static_fail[0] = act > `ACT_MAX;
        static_fail[1] = act[1:0] == entry_check_pkg::act_halted && act <= `ACT_MAX
            && regs[`IDX_SS_AR][`SS_PRIV_HI:`SS_PRIV_LO] != 2'h0;
        static_fail[2] = (ies || movss) && act != 32'h0;
        case (act[1:0])
            entry_check_pkg::act_halted: begin
                inj_ok = typ == `INJ_EXT || typ == `INJ_NMI || (typ == `INJ_HWEXC
                    && (vec == `VEC_DEBUG || vec == `VEC_MCHK));
            end
            entry_check_pkg::act_shutdown: begin
                inj_ok = typ == `INJ_NMI || (typ == `INJ_HWEXC && vec == `VEC_MCHK);
            end
            entry_check_pkg::act_await: begin
                inj_ok = 1'b0;
            end
            default: begin
                inj_ok = 1'b1;
            end
        endcase
        static_fail[3] = v && !inj_ok && act <= `ACT_MAX;
        static_fail[4] = act == 32'h3 && ctrl[`CTRL_ENTRY_MGMT];
        static_fail[5] = intr[31:4] != 28'h0;
        static_fail[6] = ies && movss;
        static_fail[7] = ies && !regs[`IDX_FLAGS][`FLAGS_IF];
        static_fail[8] = v && typ == `INJ_EXT && (ies || movss);
        static_fail[9] = v && typ == `INJ_NMI && movss;
        static_fail[10] = (intr[`INTR_MGMT_BLOCK] && !ctrl[`CTRL_IN_MGMT])
            || (!intr[`INTR_MGMT_BLOCK] && ctrl[`CTRL_ENTRY_MGMT]);
        static_fail[11] = ctrl[`CTRL_STRICT_SHADOW] && v && typ == `INJ_NMI && ies;
        static_fail[12] = ctrl[`CTRL_VIRT_NMI] && v && typ == `INJ_NMI
            && intr[`INTR_NMI];
        static_fail[13] = (pdbg & `PDBG_RSVD) != 64'h0;
        bs_want = regs[`IDX_FLAGS][`FLAGS_TRAP] && !regs[`IDX_DBGCTL][`DBGCTL_BRANCH_TRAP];
        static_fail[14] = (ies || movss || act == 32'h1)
            && pdbg[`PDBG_STEP] != bs_want;
        static_fail[`F_LINK_FMT] = !link_skip
            && (link[11:0] != 12'h000 || !fits_phys(link));
        static_fail[`F_LINK_SAME] = !link_skip && ((!ctrl[`CTRL_IN_MGMT]
            || ctrl[`CTRL_ENTRY_MGMT]) ? link == cur_ptr : link == root_ptr);
    end

    // Must check on paging turn-on or base change; otherwise skipped
    assign pdpt_needed = ext_paging
        && (!ctrl[`CTRL_PREV_PAGING] || ptb != last_ptb);

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // Loader runs alongside the checks from the start pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= entry_check_pkg::st_idle;
            fail_vec <= '0;
            mem_req <= 1'b0;
            mem_addr <= 64'h0;
            pdpt_idx <= 2'h0;
            state_load_go <= 1'b0;
            entry_pass <= 1'b0;
            entry_fail <= 1'b0;
            msr_load_start <= 1'b0;
            done_flag <= 1'b0;
            last_ptb <= 64'h0;
        end else begin
            state_load_go <= 1'b0;
            entry_pass <= 1'b0;
            entry_fail <= 1'b0;
            msr_load_start <= 1'b0;
            case (state)
                entry_check_pkg::st_idle: begin
                    if (start_pulse) begin
                        state <= entry_check_pkg::st_static;
                        state_load_go <= 1'b1;
                        done_flag <= 1'b0;
                        fail_vec <= '0;
                    end
                end
                entry_check_pkg::st_static: begin
                    fail_vec <= static_fail;
                    pdpt_idx <= 2'h0;
                    if (!link_skip && !static_fail[`F_LINK_FMT]) begin
                        state <= entry_check_pkg::st_link;
                        mem_req <= 1'b1;
                        mem_addr <= link;
                    end else if (pdpt_needed) begin
                        state <= entry_check_pkg::st_pdpt;
                        mem_req <= 1'b1;
                        mem_addr <= {ptb[63:5], 5'h00};
                    end else begin
                        state <= entry_check_pkg::st_finish;
                    end
                end
                entry_check_pkg::st_link: begin
                    if (mem_ack) begin
                        fail_vec[`F_REVISION] <= mem_rdata[31:0] != REVISION_ID;
                        if (pdpt_needed) begin
                            state <= entry_check_pkg::st_pdpt;
                            mem_addr <= {ptb[63:5], 5'h00};
                        end else begin
                            state <= entry_check_pkg::st_finish;
                            mem_req <= 1'b0;
                        end
                    end
                end
                entry_check_pkg::st_pdpt: begin
                    if (mem_ack) begin
                        if (mem_rdata[0] && ((mem_rdata & `PDPTE_RSVD) != 64'h0
                            || !fits_phys(mem_rdata))) begin
                            fail_vec[`F_PDPT] <= 1'b1;
                        end
                        pdpt_idx <= pdpt_idx + 2'h1;
                        mem_addr <= mem_addr + 64'h8;
                        if (pdpt_idx == 2'h3) begin
                            state <= entry_check_pkg::st_finish;
                            mem_req <= 1'b0;
                        end
                    end
                end
                entry_check_pkg::st_finish: begin
                    if (load_done) begin
                        state <= entry_check_pkg::st_idle;
                        done_flag <= 1'b1;
                        entry_pass <= fail_vec == '0;
                        entry_fail <= fail_vec != '0;
                        msr_load_start <= fail_vec == '0;
                        if (fail_vec == '0) begin
                            last_ptb <= ptb;
                        end
                    end
                end
                default: begin
                    state <= entry_check_pkg::st_idle;
                    mem_req <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    activity_range_a: assert property (
        state == entry_check_pkg::st_static && regs[`IDX_ACTIVITY] > `ACT_MAX |=> fail_vec[0])
        else $error("activity encoding above three not flagged");
    halt_privilege_a: assert property (
        state == entry_check_pkg::st_static && regs[`IDX_ACTIVITY] == 32'h1
        && regs[`IDX_SS_AR][6:5] != 2'h0 |=> fail_vec[1])
        else $error("halted with nonzero privilege not flagged");
    shadow_active_a: assert property (
        state == entry_check_pkg::st_static && intr[1:0] != 2'h0
        && regs[`IDX_ACTIVITY] != 32'h0 |=> fail_vec[2])
        else $error("shadow outside active state not flagged");
    shadow_pair_a: assert property (
        state == entry_check_pkg::st_static && intr[1:0] == 2'h3 |=> fail_vec[6])
        else $error("both shadow bits not flagged");
    mgmt_block_a: assert property (
        state == entry_check_pkg::st_static && ctrl[`CTRL_ENTRY_MGMT] && !intr[2]
        |=> fail_vec[10])
        else $error("missing management blocking not flagged");
    await_entry_a: assert property (
        state == entry_check_pkg::st_static && regs[`IDX_ACTIVITY] == 32'h3
        && ctrl[`CTRL_ENTRY_MGMT] |=> fail_vec[4])
        else $error("await state with management entry not flagged");
    intr_reserved_a: assert property (
        state == entry_check_pkg::st_static && intr[31:4] != 28'h0 |=> fail_vec[5])
        else $error("reserved interruptibility bits not flagged");
    debug_reserved_a: assert property (
        state == entry_check_pkg::st_static && (pdbg & `PDBG_RSVD) != 64'h0
        |=> fail_vec[13])
        else $error("reserved pending debug bits not flagged");
    link_skip_a: assert property (
        state == entry_check_pkg::st_link |-> !link_skip)
        else $error("all-ones link pointer was read");
    revision_check_a: assert property (
        state == entry_check_pkg::st_link && mem_ack
        |=> fail_vec[`F_REVISION] == ($past(mem_rdata[31:0]) != REVISION_ID))
        else $error("revision mismatch result wrong");
    no_pdpt_read_a: assert property (
        state == entry_check_pkg::st_pdpt |-> ext_paging && mem_req)
        else $error("directory entries read without extended paging");
    msr_after_load_a: assert property (
        msr_load_start |-> entry_pass && $past(load_done)
        && $past(state) == entry_check_pkg::st_finish)
        else $error("load list started before loading and checking");
    single_verdict_a: assert property (
        entry_pass |-> !entry_fail && $past(fail_vec) == '0 ##1 done_flag)
        else $error("pass given despite a failed check");

    pass_entry_c: cover property (start_pulse ##[1:40] entry_pass);
    fail_entry_c: cover property (start_pulse ##[1:40] entry_fail);
    link_read_c: cover property (state == entry_check_pkg::st_link && mem_ack);
    pdpt_walk_c: cover property (state == entry_check_pkg::st_pdpt && pdpt_idx == 2'h3 && mem_ack);
endmodule : guest_state_entry_checker

/* tb_guest_state_entry_checker.sv */
`timescale 1ns/1ps
`include "entry_check_defs.svh"
module tb_guest_state_entry_checker;
    localparam int PW = 36;
    localparam logic [31:0] REV = 32'h0000_5A5A; // Arbitrary value
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [6:0] paddr = 7'h00;
    logic [31:0] pwdata = 32'h0;
    logic mem_ack = 1'b0;
    logic [63:0] mem_rdata = 64'h0;
    logic load_done = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, mem_req, state_load_go, entry_pass, entry_fail, msr_load_start;
    logic [63:0] mem_addr;
    int failures = 0;
    int check_count = 0;
    int stall = 2;
    int wait_n = 0;
    logic [31:0] seed = 32'hbe1c1944;
    logic [31:0] act, intr, inj, flg, dbg, ss, feat, ctl, rev_word;
    logic [63:0] pdbg, link, cur, root, ptb;
    logic [63:0] last_base = 64'h0;
    logic [63:0] pte [4];
    logic [63:0] addr_q [$];

    guest_state_entry_checker #(.PHYS_WIDTH(PW), .REVISION_ID(REV)) guest_state_entry_checker_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .state_load_go(state_load_go), .load_done(load_done), .entry_pass(entry_pass),
        .entry_fail(entry_fail), .msr_load_start(msr_load_start));

    always #20 pclk = ~pclk;

    // ------------------------------------------------
    // Memory responder
    // ------------------------------------------------
    // Data line toggles while idle so a stale word never looks valid
    always @(posedge pclk) begin
        if (mem_req === 1'b1 && mem_ack === 1'b0 && wait_n >= stall) begin
            mem_ack <= 1'b1;
            mem_rdata <= (mem_addr === link) ? {~rev_word, rev_word} : pte[mem_addr[4:3]];
            addr_q.push_back(mem_addr);
            wait_n <= 0;
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            wait_n <= (mem_req === 1'b1) ? wait_n + 1 : 0;
        end
    end

    // ------------------------------------------------
    // Helpers
    // ------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic need_pdpt();
        return feat[`FEATURE_EXT_PAGING] && !ctl[`CTRL_GUEST64] && (!ctl[`CTRL_PREV_PAGING] || ptb != last_base);
    endfunction : need_pdpt

    function automatic logic [18:0] expect_fail();
        logic [18:0] f;
        logic v, ok;
        logic [2:0] t;
        logic [7:0] vc;
        v = inj[`INJ_VALID];
        t = inj[`INJ_TYPE_HI:`INJ_TYPE_LO];
        vc = inj[7:0];
        f = '0;
        ok = 1'b1;
        if (act == 1) begin
            ok = t == `INJ_EXT || t == `INJ_NMI || (t == `INJ_HWEXC && (vc == `VEC_DEBUG || vc == `VEC_MCHK));
        end else if (act == 2) begin
            ok = t == `INJ_NMI || (t == `INJ_HWEXC && vc == `VEC_MCHK);
        end else if (act == 3) begin
            ok = 1'b0;
        end
        f[0] = act > `ACT_MAX;
        f[1] = act == 1 && ss[6:5] != 0;
        f[2] = intr[1:0] != 0 && act != 0;
        f[3] = v && !ok;
        f[4] = act == 3 && ctl[`CTRL_ENTRY_MGMT];
        f[5] = intr[31:4] != 0;
        f[6] = intr[1:0] == 2'h3;
        f[7] = intr[0] && !flg[`FLAGS_IF];
        f[8] = v && t == `INJ_EXT && intr[1:0] != 0;
        f[9] = v && t == `INJ_NMI && intr[1];
        f[10] = (!ctl[`CTRL_IN_MGMT] && intr[2]) || (ctl[`CTRL_ENTRY_MGMT] && !intr[2]);
        f[11] = ctl[`CTRL_STRICT_SHADOW] && v && t == `INJ_NMI && intr[0];
        f[12] = ctl[`CTRL_VIRT_NMI] && v && t == `INJ_NMI && intr[3];
        f[13] = (pdbg & `PDBG_RSVD) != 0;
        f[14] = (intr[1:0] != 0 || act == 1) && pdbg[14] != (flg[8] && !dbg[1]);
        f[15] = link != '1 && (link[11:0] != 0 || (link >> PW) != 0);
        f[16] = link != '1 && link == ((!ctl[1] || ctl[2]) ? cur : root);
        f[17] = link != '1 && !f[15] && rev_word != REV;
        for (int i = 0; i < 4; i++) begin
            f[18] |= need_pdpt() && pte[i][0] && ((pte[i] & `PDPTE_RSVD) != 0 || (pte[i] >> PW) != 0);
        end
        return f;
    endfunction : expect_fail

    task automatic cmp(input logic [63:0] got, input logic [63:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp

    task automatic apb(input logic w, input logic [6:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        cmp(n < 50, 1'b1, "apb answer");
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic setf(input logic [31:0] a, input logic [31:0] i, input logic [31:0] j,
                        input logic [31:0] c);
        act = a;
        intr = i;
        inj = j;
        ctl = c;
        {flg, dbg, ss, feat, pdbg, ptb} = '0;
        link = '1;
        cur = 64'h1000;
        root = 64'h2000;
        rev_word = REV;
        pte = '{default: 64'h0};
    endtask : setf

    task automatic run(input int hold, input string name);
        logic [31:0] v [17];
        logic [31:0] r;
        logic e, got, gp, gm, need, sl;
        logic [18:0] ex;
        int k, nr, base;
        v = '{act, intr, pdbg[31:0], pdbg[63:32], link[31:0], link[63:32], inj, flg, dbg, ss,
              feat, ptb[31:0], ptb[63:32], cur[31:0], cur[63:32], root[31:0], root[63:32]};
        need = need_pdpt();
        ex = expect_fail();
        nr = (link != '1 && !ex[15]) ? 1 : 0;
        base = nr;
        nr += need ? 4 : 0;
        for (int i = 0; i < 17; i++) begin
            wr(`OFF_ACTIVITY + 7'(4 * i), v[i]);
        end
        addr_q.delete();
        load_done <= 1'b0;
        wr(`OFF_CTRL, ctl | 32'h1);
        {got, gp, gm, sl, k} = '0;
        while (!got && k < 400) begin
            @(posedge pclk);
            k++;
            if (state_load_go === 1'b1) sl = 1'b1;
            if (k == hold) load_done <= 1'b1;
            if (entry_pass === 1'b1 || entry_fail === 1'b1) begin
                got = 1'b1;
                gp = entry_pass;
                gm = msr_load_start;
                cmp(k > hold, 1'b1, "verdict before load done");
            end
        end
        cmp(got, 1'b1, "verdict seen");
        cmp(gp, ex == 0, "pass");
        cmp(gm, ex == 0, "load list start");
        cmp(sl, 1'b1, "state load go");
        if (base > 0 && addr_q.size() > 0) cmp(addr_q[0], link, "link address");
        apb(1'b0, `OFF_FAIL, 32'h0, r, e);
        cmp(r, {13'h0, ex}, "fail vector");
        apb(1'b0, `OFF_STATUS, 32'h0, r, e);
        cmp(r[2:0], {ex == 0, 2'b10}, "status");
        cmp(addr_q.size(), nr, "read count");
        for (int i = 0; i < 4 && need; i++) begin
            cmp(addr_q[base + i], {ptb[63:5], 5'h0} + 64'(8 * i), "directory address");
        end
        if (ex == 0) last_base = ptb;
        $display("test %s done, expected vector %h", name, ex);
    endtask : run

    task report_and_stop();
        $display("checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------
    // Sequence
    // ------------------------------------------------
    logic [31:0] rv;
    logic ev;
    logic [7:0] vsel [3] = '{`VEC_DEBUG, `VEC_MCHK, 8'h0E};
    logic [63:0] lk [6] = '{64'h1_2345_5000, 64'h1_2345_5000, 64'h1_2345_5008,
                            64'h10_0000_0000, 64'h1000, 64'h2000};
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `OFF_LINK_HI, 32'h0, rv, ev);
        cmp(rv, `LINK_RESET, "link reset");
        apb(1'b0, 7'h50, 32'h0, rv, ev);
        cmp({ev, rv}, {1'b1, 32'h0}, "unmapped read");
        wr(`OFF_STATUS, 32'hFFFF_FFFF);
        apb(1'b0, `OFF_STATUS, 32'h0, rv, ev);
        cmp(rv, 32'h0, "status read only");
        setf(0, 0, 0, 0);
        run(1, "clean");
        setf(3, 32'h4, 0, 32'h6);
        run(2, "await with entry");
        setf(1, 0, 32'h8000_0200, 0);
        run(30, "halted nmi");
        setf(2, 0, 32'h8000_0312, 0);
        run(1, "shutdown machine check");
        setf(2, 0, 32'h8000_0301, 0);
        run(1, "shutdown debug");
        setf(1, 0, 0, 0);
        ss = 32'h20;
        run(1, "halted privilege");
        setf(0, 32'h8, 32'h8000_0200, 32'h8);
        run(1, "virtual nmi");
        setf(0, 32'h1, 32'h8000_0200, 32'h40);
        flg = 32'h200;
        run(1, "strict shadow");
        setf(1, 0, 0, 0);
        flg = 32'h100;
        pdbg = 64'h4000;
        run(1, "single step");
        for (int i = 0; i < 6; i++) begin
            setf(0, 0, 0, (i == 5) ? 32'h2 : 32'h0);
            link = lk[i];
            rev_word = (i == 1) ? ~REV : REV;
            run(40, "link");
        end
        setf(0, 0, 0, 0);
        feat = 32'h20;
        ptb = 64'h1_2345_6780;
        pte[3] = 64'h6;
        run(2, "directory fresh");
        ctl = 32'h20;
        run(2, "directory same base");
        ptb = 64'h1_2345_6800;
        pte[2] = 64'h3;
        stall = 5;
        run(60, "directory reserved");
        ctl = 32'h30;
        run(2, "long mode guest");
        for (int n = 0; n < 60; n++) begin
            setf(rnd() % 5, (n % 8 == 0) ? rnd() : rnd() & 32'hF, 0, rnd() & 32'h4E);
            inj = (rnd() & 32'h8000_0700) | {24'h0, vsel[n % 3]};
            flg = rnd() & 32'h300;
            dbg = rnd() & 32'h2;
            ss = rnd() & 32'h60;
            pdbg = (n % 6 == 0) ? {rnd(), rnd()} : {32'h0, rnd() & 32'h4000};
            stall = (n % 2) * 3;
            run((n % 2) ? 30 : 1, "random");
        end
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `OFF_LINK_LO, 32'h0, rv, ev);
        cmp(rv, `LINK_RESET, "link after second reset");
        report_and_stop();
    end

    initial begin
        repeat (40000) @(posedge pclk);
        failures++;
        $display("mismatch at %0t: watchdog expired", $time);
        report_and_stop();
    end
endmodule : tb_guest_state_entry_checker
